// ---- core/frame_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
    logic       toggle;
    logic [7:0] data;
    logic       valid;
    modport link (output toggle, output data, output valid);
    modport core (input toggle, input data, input valid);
endinterface : frame_if
`default_nettype wire

// ---- core/isolated_switch_serial_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module isolated_switch_serial_control
    import switch_ctrl_pkg::*;
(
    // System
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Serial pins
    input  wire logic                sclk,
    input  wire logic                cs_n,
    input  wire logic                si,
    output logic                     so_out,
    output logic                     so_oe_n,
    // Control and status
    input  wire logic                output_disable_n,
    input  wire logic [CHANNELS-1:0] overtemp,
    input  wire logic                supply_low,
    output logic                     overtemp_alert_n_out,
    output logic                     overtemp_alert_n_oe_n,
    output logic [CHANNELS-1:0]      channel_switch_outputs
);
    ////////////////////////////////////////////////////////////////////
    // Link side, clocked by the serial clock and by the rising edge of cs_n
    frame_if frm ();

    serial_link u_link (
        .sclk             (sclk),
        .cs_n             (cs_n),
        .si               (si),
        .so_out           (so_out),
        .so_oe_n          (so_oe_n),
        .output_disable_n (output_disable_n),
        .frm              (frm.link)
    );

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Edge of a toggle after two settling flops
    function automatic logic toggle_edge(input logic [2:0] sync);
        toggle_edge = sync[2] ^ sync[1];
    endfunction : toggle_edge

    // Bad-frame count saturates, so it never wraps back to clean
    function automatic logic [2:0] fail_step(input logic [2:0] cnt);
        if (cnt == FAIL_LIMIT) begin
            fail_step = cnt;
        end else begin
            fail_step = cnt + 3'h1;
        end
    endfunction : fail_step

    // Last bad frame before the channels are dropped
    function automatic logic fail_final(input logic [2:0] cnt);
        fail_final = (cnt == FAIL_LIMIT - 3'h1);
    endfunction : fail_final

    ////////////////////////////////////////////////////////////////////
    // State
    logic [2:0]           tog_sync_reg;
    logic [1:0]           dis_sync_reg;
    logic [CHANNELS-1:0]  hot_sync0_reg;
    logic [CHANNELS-1:0]  hot_sync1_reg;
    logic [1:0]           low_sync_reg;
    logic                 alert_reg;
    logic [WORD_BITS-1:0] word_reg;
    logic                 word_ok_reg;
    logic                 word_evt_reg;
    logic [CHANNELS-1:0]  latch_reg;
    logic [2:0]           fail_reg;
    logic                 frame_evt;
    logic                 enabled;

    ////////////////////////////////////////////////////////////////////
    // Crossing; word and status stand still while the toggle settles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_sync_reg <= '0;
        end else begin
            tog_sync_reg <= {tog_sync_reg[1:0], frm.toggle};
        end
    end
    assign frame_evt = toggle_edge(tog_sync_reg);

    // Disable level, for the clocked decisions only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dis_sync_reg <= '0;
        end else begin
            dis_sync_reg <= {dis_sync_reg[0], output_disable_n};
        end
    end
    assign enabled = dis_sync_reg[1];

    ////////////////////////////////////////////////////////////////////
    // Frame capture; one clock of latency buys a clean copy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_reg    <= LATCH_RESET;
            word_ok_reg <= 1'b0;
        end else if (frame_evt) begin
            word_reg    <= frm.data;
            word_ok_reg <= frm.valid;
        end
    end

    // Events seen while disabled come from the link reset, not a frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_evt_reg <= 1'b0;
        end else begin
            word_evt_reg <= frame_evt && enabled;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Latches; disable clears them at once, without a clock
    always_ff @(posedge clk or negedge rst_n or negedge output_disable_n) begin
        if (!rst_n || !output_disable_n) begin
            latch_reg <= LATCH_RESET;
        end else if (word_evt_reg && word_ok_reg) begin
            latch_reg <= word_reg;
        end else if (word_evt_reg && fail_final(fail_reg)) begin
            latch_reg <= LATCH_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transfer failure count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fail_reg <= '0;
        end else if (!enabled) begin
            fail_reg <= '0;
        end else if (word_evt_reg && word_ok_reg) begin
            fail_reg <= '0;
        end else if (word_evt_reg) begin
            fail_reg <= fail_step(fail_reg);
        end
    end

    assign channel_switch_outputs = latch_reg;

    ////////////////////////////////////////////////////////////////////
    // Fault inputs are pins; each passes two flops before the OR
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hot_sync0_reg <= '0;
        end else begin
            hot_sync0_reg <= overtemp;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hot_sync1_reg <= '0;
        end else begin
            hot_sync1_reg <= hot_sync0_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_sync_reg <= '0;
        end else begin
            low_sync_reg <= {low_sync_reg[0], supply_low};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alert, open drain: pull low on any fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_reg <= 1'b0;
        end else begin
            alert_reg <= (|hot_sync1_reg) | low_sync_reg[1];
        end
    end

    // Pin only ever pulls low; the current source gives the high level
    assign overtemp_alert_n_out  = 1'b0;
    assign overtemp_alert_n_oe_n = ~alert_reg;
endmodule : isolated_switch_serial_control
`default_nettype wire

// ---- core/serial_link.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_link
    import switch_ctrl_pkg::*;
(
    // Serial pins
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       si,
    output logic            so_out,
    output logic            so_oe_n,
    // Clear
    input  wire logic       output_disable_n,
    // Frame towards core
    frame_if.link           frm
);
    logic [7:0]       shift_reg;
    logic [CNT_W-1:0] count_reg;
    logic             toggle_reg;
    logic             any_reg;
    logic             lead_reg;
    logic             so_neg_reg;

    // Selection acts as reset of count, so each frame counts alone
    always_ff @(posedge sclk or posedge cs_n or negedge output_disable_n) begin
        if (!output_disable_n) begin
            count_reg <= '0;
            any_reg   <= 1'b0;
        end else if (cs_n) begin
            count_reg <= '0;
            any_reg   <= 1'b0;
        end else begin
            count_reg <= count_reg + 1'b1;
            any_reg   <= 1'b1;
        end
    end

    always_ff @(posedge sclk or negedge output_disable_n) begin
        if (!output_disable_n) begin
            shift_reg <= LATCH_RESET;
        end else if (!cs_n) begin
            shift_reg <= {shift_reg[6:0], si};
        end
    end

    // Outgoing bit is the msb, updated after falling edge
    always_ff @(negedge sclk or negedge output_disable_n) begin
        if (!output_disable_n) begin
            so_neg_reg <= 1'b0;
        end else begin
            so_neg_reg <= shift_reg[7];
        end
    end

    // Until the first falling edge the current msb shows directly
    always_ff @(negedge sclk or posedge cs_n or negedge output_disable_n) begin
        if (!output_disable_n) begin
            lead_reg <= 1'b0;
        end else if (cs_n) begin
            lead_reg <= 1'b0;
        end else begin
            lead_reg <= 1'b1;
        end
    end
    assign so_out = lead_reg ? so_neg_reg : shift_reg[7];

    assign so_oe_n = cs_n;

    // Frame closes on cs rising; data is stable since sclk stays high
    always_ff @(posedge cs_n or negedge output_disable_n) begin
        if (!output_disable_n) begin
            toggle_reg <= 1'b0;
            frm.data   <= LATCH_RESET;
            frm.valid  <= 1'b0;
        end else begin
            toggle_reg <= ~toggle_reg;
            frm.data   <= shift_reg;
            frm.valid  <= any_reg && (count_reg == '0);
        end
    end
    assign frm.toggle = toggle_reg;
endmodule : serial_link
`default_nettype wire

// ---- core/switch_ctrl_pkg.sv ----
package switch_ctrl_pkg;
    localparam int          CHANNELS      = 8;
    localparam int          WORD_BITS     = 8;
    localparam int          CNT_W         = 3;
    localparam logic [2:0]  FAIL_LIMIT    = 3'h4;
    localparam logic [7:0]  LATCH_RESET   = 8'h00;
endpackage : switch_ctrl_pkg

// ---- verif/isolated_switch_serial_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module isolated_switch_serial_control_test
    import switch_ctrl_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, output_disable_n = 1'b0, supply_low = 1'b0;
    logic sclk, cs_n, si, so_out, so_oe_n, alert_out, alert_oe_n;
    logic [CHANNELS-1:0] overtemp = '0, outs;
    int miscompares = 0, check_count = 0, cycles = 0;
    always #20 clk = ~clk;
    isolated_switch_serial_control u_dut (.clk, .rst_n, .sclk, .cs_n, .si, .so_out, .so_oe_n,
        .output_disable_n, .overtemp, .supply_low, .overtemp_alert_n_out(alert_out),
        .overtemp_alert_n_oe_n(alert_oe_n), .channel_switch_outputs(outs));
    spi_master_model u_master (.sclk, .cs_n, .si, .so_out, .so_oe_n);
    task automatic send(input logic [31:0] d, input int n);
        @(posedge clk) #7;
        u_master.frame(d, n);
        repeat (8) @(posedge clk);
        #1;
    endtask : send
    task automatic t_frames;
        send(32'hA5, 8);
        `CHK(outs, 8'hA5)
        send(32'h3C, 8);
        `CHK(u_master.rx[7:0], 8'hA5)
        `CHK(u_master.oe_bad, 1'b0)
        `CHK(u_master.lead, 1'b1)
        `CHK(so_oe_n, 1'b1)
        send(32'h1234, 16);
        `CHK(u_master.rx[15:0], 16'h3C12)
        `CHK(u_master.lead, 1'b0)
        `CHK(outs, 8'h34)
    endtask : t_frames
    task automatic t_bad;
        send(32'h1FF, 9);
        `CHK(outs, 8'h34)
        send(32'h7F, 7);
        `CHK(outs, 8'h34)
        send(32'hF0F, 12);
        `CHK(outs, 8'h34)
        send(32'h3, 2);
        `CHK(outs, 8'h00)
        send(32'h81, 8);
        `CHK(outs, 8'h81)
        send(32'h0, 0);
        `CHK(outs, 8'h81)
    endtask : t_bad
    task automatic t_disable;
        @(posedge clk) output_disable_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(outs, 8'h00)
        u_master.frame(32'hC3, 8);
        repeat (4) @(posedge clk);
        output_disable_n <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        `CHK(outs, 8'h00)
        send(32'h5A, 8);
        `CHK(outs, 8'h5A)
    endtask : t_disable
    task automatic t_alert;
        @(posedge clk) overtemp <= 8'h20;
        repeat (6) @(posedge clk);
        #1;
        `CHK(alert_oe_n, 1'b0)
        `CHK(alert_out, 1'b0)
        @(posedge clk) overtemp <= 8'h00;
        repeat (6) @(posedge clk);
        #1;
        `CHK(alert_oe_n, 1'b1)
        @(posedge clk) supply_low <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK(alert_oe_n, 1'b0)
        @(posedge clk) supply_low <= 1'b0;
    endtask : t_alert
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        output_disable_n <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(outs, 8'h00)
        t_frames;
        t_bad;
        t_disable;
        t_alert;
        tally_and_finish;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish;
        end
    end
endmodule : isolated_switch_serial_control_test
`default_nettype wire

// ---- verif/spi_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    output logic     sclk, cs_n, si,
    input wire logic so_out, so_oe_n
);
    logic [31:0] rx;
    logic        oe_bad;
    logic        lead;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Clock stands high outside frames; si inverted so no stale value reads right
    task automatic frame(input logic [31:0] d, input int n);
        rx = '0;
        oe_bad = 1'b0;
        cs_n = 1'b0;
        #32;
        lead = so_out;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            si = d[i];
            #32 sclk = 1'b1;
            rx = {rx[30:0], so_out};
            oe_bad |= so_oe_n;
            #32;
        end
        cs_n = 1'b1;
        si = ~si;
    endtask : frame
endmodule : spi_master_model
`default_nettype wire

// ---- verif/switch_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module switch_ctrl_chk
    import switch_ctrl_pkg::*;
(
    input wire logic                clk, rst_n, sclk, cs_n, si, so_out, so_oe_n,
    input wire logic                output_disable_n, supply_low,
    input wire logic                overtemp_alert_n_out, overtemp_alert_n_oe_n,
    input wire logic [CHANNELS-1:0] overtemp, channel_switch_outputs
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] gap_reg;
    // Cycles since select release, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) gap_reg <= 3'h7;
        else if ($rose(cs_n)) gap_reg <= 3'h0;
        else if (gap_reg != 3'h7) gap_reg <= gap_reg + 3'h1;
    end
    sequence dis_held; !output_disable_n [*2]; endsequence
    sequence hot; (|overtemp) || supply_low; endsequence
    oe_cs_a: assert property (so_oe_n == cs_n) else $error("so enable off select");
    alert_low_a: assert property (overtemp_alert_n_out == 1'b0)
        else $error("alert drives high");
    alert_hot_a: assert property (hot |-> ##[0:4] !overtemp_alert_n_oe_n)
        else $error("alert not pulled");
    dis_clear_a: assert property (!output_disable_n |-> ##[0:1] channel_switch_outputs == 8'h00)
        else $error("disable left outputs on");
    dis_hold_a: assert property (dis_held |-> channel_switch_outputs == 8'h00)
        else $error("outputs on while disabled");
    reset_off_a: assert property ($rose(rst_n) |-> channel_switch_outputs == 8'h00)
        else $error("outputs on after reset");
    upd_win_a: assert property ($changed(channel_switch_outputs) && output_disable_n &&
        $past(output_disable_n) |-> gap_reg < 3'h6) else $error("outputs moved outside window");
    // Register persists across frames, so the delay spans frame gaps
    shift_a: assert property (@(posedge sclk) disable iff (!output_disable_n)
        1'b1 |-> ##8 so_out == $past(si, 8)) else $error("shift path broken");
endmodule : switch_ctrl_chk
bind isolated_switch_serial_control switch_ctrl_chk u_chk (.clk, .rst_n, .sclk, .cs_n, .si,
    .so_out, .so_oe_n, .output_disable_n, .supply_low, .overtemp_alert_n_out,
    .overtemp_alert_n_oe_n, .overtemp, .channel_switch_outputs);
`default_nettype wire
